/* src/pis_store.sv */
`timescale 1ns/1ps
`default_nettype none
module pis_store (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic param_wr_i,
    input wire logic [4:0] param_addr_i,
    input wire logic [15:0] param_wdata_i,
    input wire logic param_from_keypad_i,
    input wire logic keys_held_i,
    output logic [15:0] param_rdata_o,
    output logic busy_o,
    output logic init_done_o,
    output logic save_done_o,
    output logic write_refused_o,
    output logic user_image_valid_o
);

    // Registered state and its next value.
    pis_pkg::pis_state_t st;
    pis_pkg::pis_state_t next_st;

    // Pending command and trigger as currently stored.
    logic [15:0] cmd;
    logic [15:0] trig;
    // A command or save is processed in the cycle after it is stored.
    logic pending;
    // Motor constants for the capacity in the current derivation.
    logic [15:0] deriv_cap;
    logic [15:0] deriv_type;
    logic [5:0][15:0] motor_vals;

    assign cmd = st.settings[pis_pkg::IDX_INIT_COMMAND];
    assign trig = st.settings[pis_pkg::IDX_SAVE_TRIGGER];
    assign pending = (cmd != pis_pkg::CMD_NONE) ||
                     (trig != pis_pkg::CMD_NONE);

    // Derives the six dependent constants from type and capacity.
    function automatic logic [5:0][15:0] derive(input logic [15:0] cap,
                                               input logic [15:0] mtype);
        logic [15:0] rating;
        logic [15:0] delay;
        logic [15:0] k;
        logic [31:0] prod;
        logic [15:0] cur;
        logic [31:0] nl;
        logic hp;
        logic found;
        rating = pis_pkg::STD_RATINGS[pis_pkg::NUM_RATINGS - 1];
        delay = pis_pkg::SEARCH_DELAYS[pis_pkg::NUM_RATINGS - 1];
        found = 1'b0;
        // Snap to the smallest standard rating not below the setting.
        for (int r = 0; r < pis_pkg::NUM_RATINGS; r++) begin
            if (!found && cap <= pis_pkg::STD_RATINGS[r]) begin
                rating = pis_pkg::STD_RATINGS[r];
                delay = pis_pkg::SEARCH_DELAYS[r];
                found = 1'b1;
            end
        end
        // HP rated motors follow the 460 V/60 Hz figures, others 400 V.
        hp = (mtype == pis_pkg::TYPE_HP);
        k = hp ? pis_pkg::CUR_K_HP : pis_pkg::CUR_K_STD;
        prod = 32'(rating) * 32'(k);
        cur = 16'(prod / 32'(pis_pkg::PCT_DIV));
        nl = 32'(cur) * 32'(pis_pkg::NOLOAD_PCT) / 32'(pis_pkg::PCT_DIV);
        derive[0] = cur;
        derive[1] = nl[15:0];
        derive[2] = hp ? pis_pkg::R1_HP : pis_pkg::R1_STD;
        derive[3] = hp ? pis_pkg::X_HP : pis_pkg::X_STD;
        derive[4] = hp ? pis_pkg::RELATED_HP : pis_pkg::RELATED_STD;
        derive[5] = delay;
    endfunction

    // A capacity write derives from the new value, otherwise stored ones.
    always_comb begin
        deriv_type = st.settings[pis_pkg::IDX_MOTOR_TYPE_SELECT];
        if (param_wr_i && param_addr_i == pis_pkg::IDX_MOTOR_RATED_CAPACITY)
        begin
            deriv_cap = param_wdata_i;
        end else begin
            deriv_cap = st.settings[pis_pkg::IDX_MOTOR_RATED_CAPACITY];
        end
        motor_vals = derive(deriv_cap, deriv_type);
    end

    // Next-state logic: process a pending command or save, else take writes.
    always_comb begin
        logic use_user;
        logic in_comm;
        logic in_logic;
        logic keypad_locked;
        use_user = 1'b0;
        in_comm = 1'b0;
        in_logic = 1'b0;
        keypad_locked = 1'b0;
        next_st = st;
        next_st.init_done = 1'b0;
        next_st.save_done = 1'b0;
        next_st.refused = 1'b0;
        next_st.rdata = st.settings[param_addr_i];
        if (pending) begin
            // User image only when selected and actually saved.
            use_user = (st.settings[pis_pkg::IDX_INIT_METHOD_SELECT] ==
                         pis_pkg::METHOD_USER) && st.image_valid;
            for (int i = 0; i < pis_pkg::NUM_SETTINGS; i++) begin
                in_comm = (i >= pis_pkg::COMM_FIRST) &&
                          (i <= pis_pkg::COMM_LAST);
                in_logic = (i >= pis_pkg::LOGIC_FIRST) &&
                           (i <= pis_pkg::LOGIC_LAST);
                unique case (cmd)
                    pis_pkg::CMD_ALL: begin
                        if (use_user) begin
                            next_st.settings[i] = st.user_image[i];
                        end else begin
                            next_st.settings[i] =
                                pis_pkg::FACTORY_DEFAULTS[i];
                        end
                    end
                    pis_pkg::CMD_NO_COMM: begin
                        if (!in_comm) begin
                            next_st.settings[i] =
                                pis_pkg::FACTORY_DEFAULTS[i];
                        end
                    end
                    pis_pkg::CMD_LOGIC_ONLY: begin
                        if (in_logic) begin
                            next_st.settings[i] =
                                pis_pkg::FACTORY_DEFAULTS[i];
                        end
                    end
                    default: begin
                        // Zero, motor-only and unknown codes touch nothing.
                        next_st.settings[i] = st.settings[i];
                    end
                endcase
            end
            if (cmd == pis_pkg::CMD_MOTOR) begin
                // Rederive the motor constants in place.
                for (int m = 0; m < 6; m++) begin
                    next_st.settings[5'(int'(pis_pkg::IDX_MOTOR_RATED_CURRENT)
                        + m)] = motor_vals[m];
                end
            end
            if (cmd != pis_pkg::CMD_NONE) begin
                next_st.init_done = 1'b1;
            end
            // The command always reverts once processed.
            next_st.settings[pis_pkg::IDX_INIT_COMMAND] =
                pis_pkg::CMD_NONE;
            if (trig == pis_pkg::TRIGGER_SAVE &&
                st.settings[pis_pkg::IDX_INIT_METHOD_SELECT] ==
                pis_pkg::METHOD_USER &&
                st.settings[pis_pkg::IDX_PROTECT] == pis_pkg::PROTECT_OFF)
            begin
                // Snapshot overwrites any earlier image.
                next_st.user_image = st.settings;
                next_st.user_image[pis_pkg::IDX_SAVE_TRIGGER] =
                    pis_pkg::CMD_NONE;
                next_st.image_valid = 1'b1;
                next_st.save_done = 1'b1;
            end
            // Otherwise the image stays as it is.
            // Trigger returns to zero whatever the outcome.
            next_st.settings[pis_pkg::IDX_SAVE_TRIGGER] =
                pis_pkg::CMD_NONE;
            if (param_wr_i) begin
                // Writes during processing are dropped and flagged.
                next_st.refused = 1'b1;
            end
        end else if (param_wr_i) begin
            // Keypad may change method or command only with both keys held.
            keypad_locked = param_from_keypad_i && !keys_held_i &&
                ((param_addr_i == pis_pkg::IDX_INIT_COMMAND) ||
                 (param_addr_i == pis_pkg::IDX_INIT_METHOD_SELECT));
            if (keypad_locked) begin
                next_st.refused = 1'b1;
            end else begin
                next_st.settings[param_addr_i] = param_wdata_i;
                if (param_addr_i == pis_pkg::IDX_MOTOR_RATED_CAPACITY) begin
                    // Dependent constants follow a capacity write.
                    for (int m = 0; m < 6; m++) begin
                        next_st.settings[5'(int'(
                            pis_pkg::IDX_MOTOR_RATED_CURRENT) + m)] =
                            motor_vals[m];
                    end
                end
            end
        end
    end

    // State register; settings start from the factory table.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.settings <= pis_pkg::FACTORY_DEFAULTS;
            st.user_image <= '0;
            st.image_valid <= 1'b0;
            st.rdata <= 16'h0000;
            st.init_done <= 1'b0;
            st.save_done <= 1'b0;
            st.refused <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state, busy from the pending term.
    assign param_rdata_o = st.rdata;
    assign busy_o = pending;
    assign init_done_o = st.init_done;
    assign save_done_o = st.save_done;
    assign write_refused_o = st.refused;
    assign user_image_valid_o = st.image_valid;

endmodule
`default_nettype wire

/* src/pis_pkg.sv */
`default_nettype none
package pis_pkg;

    // Geometry of the setting store.
    localparam int NUM_SETTINGS = 32;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;

    // Setting indices.
    localparam logic [4:0] IDX_INIT_COMMAND = 5'h00;
    localparam logic [4:0] IDX_INIT_METHOD_SELECT = 5'h01;
    localparam logic [4:0] IDX_SAVE_TRIGGER = 5'h02;
    localparam logic [4:0] IDX_PROTECT = 5'h03;
    localparam logic [4:0] IDX_MOTOR_TYPE_SELECT = 5'h04;
    localparam logic [4:0] IDX_MOTOR_RATED_CAPACITY = 5'h05;
    localparam logic [4:0] IDX_MOTOR_RATED_CURRENT = 5'h06;
    localparam logic [4:0] IDX_MOTOR_NOLOAD_CURRENT = 5'h07;
    localparam logic [4:0] IDX_MOTOR_PCT_R1 = 5'h08;
    localparam logic [4:0] IDX_MOTOR_PCT_X = 5'h09;
    localparam logic [4:0] IDX_MOTOR_RELATED_CONSTANT = 5'h0A;
    localparam logic [4:0] IDX_SEARCH_DELAY_SECOND = 5'h0B;
    localparam int COMM_FIRST = 12;
    localparam int COMM_LAST = 15;
    localparam int LOGIC_FIRST = 16;
    localparam int LOGIC_LAST = 23;

    // Command and selector encodings.
    localparam logic [15:0] CMD_NONE = 16'h0000;
    localparam logic [15:0] CMD_ALL = 16'h0001;
    localparam logic [15:0] CMD_MOTOR = 16'h0002;
    localparam logic [15:0] CMD_NO_COMM = 16'h000B;
    localparam logic [15:0] CMD_LOGIC_ONLY = 16'h000C;
    localparam logic [15:0] METHOD_FACTORY = 16'h0000;
    localparam logic [15:0] METHOD_USER = 16'h0001;
    localparam logic [15:0] TRIGGER_SAVE = 16'h0001;
    localparam logic [15:0] PROTECT_OFF = 16'h0000;
    localparam logic [15:0] TYPE_HP = 16'h0001;

    // Standard nominal ratings in 0.01 kW steps, ascending.
    localparam int NUM_RATINGS = 8;
    localparam logic [7:0][15:0] STD_RATINGS = {
        16'h05DC, 16'h044C, 16'h02EE, 16'h0226,
        16'h0172, 16'h00DC, 16'h0096, 16'h004B};
    // Auto-search delay 2 per rating, in 0.1 s steps.
    localparam logic [7:0][15:0] SEARCH_DELAYS = {
        16'h0014, 16'h0014, 16'h000F, 16'h000F,
        16'h000A, 16'h000A, 16'h0005, 16'h0005};

    // Motor derivation figures (percent scale factors).
    localparam logic [15:0] CUR_K_STD = 16'h00C8;
    localparam logic [15:0] CUR_K_HP = 16'h00AF;
    localparam logic [15:0] PCT_DIV = 16'h0064;
    localparam logic [15:0] NOLOAD_PCT = 16'h0028;
    localparam logic [15:0] R1_STD = 16'h0190;
    localparam logic [15:0] R1_HP = 16'h01A4;
    localparam logic [15:0] X_STD = 16'h0320;
    localparam logic [15:0] X_HP = 16'h0352;
    localparam logic [15:0] RELATED_STD = 16'h0055;
    localparam logic [15:0] RELATED_HP = 16'h0058;

    // Built-in factory defaults, highest index first.
    localparam logic [31:0][15:0] FACTORY_DEFAULTS = {
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0001, 16'h0001,
        16'h0005, 16'h0055, 16'h0320, 16'h0190,
        16'h0078, 16'h012C, 16'h0096, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // Whole state of the store, registered as one word.
    typedef struct packed {
        logic [31:0][15:0] settings;
        logic [31:0][15:0] user_image;
        logic image_valid;
        logic [15:0] rdata;
        logic init_done;
        logic save_done;
        logic refused;
    } pis_state_t;

endpackage
`default_nettype wire

/* tb/pis_store_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the setting store from its ports only.
module pis_store_properties (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic param_wr_i,
    input wire logic [4:0] param_addr_i,
    input wire logic [15:0] param_wdata_i,
    input wire logic param_from_keypad_i,
    input wire logic keys_held_i,
    input wire logic [15:0] param_rdata_o,
    input wire logic busy_o,
    input wire logic init_done_o,
    input wire logic save_done_o,
    input wire logic write_refused_o,
    input wire logic user_image_valid_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Locked keypad write to the command or method entry.
    logic lock;
    // A write that the store takes.
    logic acc;
    assign lock = param_from_keypad_i && !keys_held_i && param_addr_i < 5'h02;
    assign acc = param_wr_i && !busy_o && !lock;
    key_lock_a: assert property (param_wr_i && !busy_o && lock
        |=> write_refused_o) else $error("locked write not refused");
    key_open_a: assert property (acc |=> !write_refused_o)
        else $error("taken write flagged refused");
    init_run_a: assert property (acc && param_addr_i == 5'h00 &&
        param_wdata_i != 16'h0000 |=> busy_o ##1 init_done_o)
        else $error("command not processed");
    cmd_idle_a: assert property (acc && param_addr_i == 5'h00 &&
        param_wdata_i == 16'h0000 |=> !busy_o ##1 !init_done_o)
        else $error("zero command started work");
    cmd_clear_a: assert property (init_done_o |-> !busy_o &&
        $past(busy_o)) else $error("command not cleared");
    save_clear_a: assert property (acc && param_addr_i == 5'h02 &&
        param_wdata_i != 16'h0000 |=> busy_o ##1 !busy_o)
        else $error("save trigger not cleared");
    save_valid_a: assert property (save_done_o |->
        user_image_valid_o && $past(busy_o)) else $error("bad save");
    valid_hold_a: assert property (user_image_valid_o |=>
        user_image_valid_o) else $error("image valid dropped");
    cover property (init_done_o);
    cover property (save_done_o);
    cover property (write_refused_o);
endmodule
bind pis_store pis_store_properties u_props (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .param_wr_i(param_wr_i),
    .param_addr_i(param_addr_i),
    .param_wdata_i(param_wdata_i),
    .param_from_keypad_i(param_from_keypad_i),
    .keys_held_i(keys_held_i),
    .param_rdata_o(param_rdata_o),
    .busy_o(busy_o),
    .init_done_o(init_done_o),
    .save_done_o(save_done_o),
    .write_refused_o(write_refused_o),
    .user_image_valid_o(user_image_valid_o)
);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic param_wr_i = 1'b0;
    logic param_from_keypad_i = 1'b0;
    logic keys_held_i = 1'b0;
    logic [4:0] param_addr_i = 5'h00;
    logic [15:0] param_wdata_i = 16'h0000;
    logic [15:0] param_rdata_o;
    logic busy_o, init_done_o, save_done_o, write_refused_o;
    logic user_image_valid_o;
    int n_errors = 0;
    int check_count = 0;
    int cap;
    // Model settings and model user image.
    logic [15:0] mdl [32];
    logic [15:0] img [32];
    pis_store dut (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .param_wr_i(param_wr_i),
        .param_addr_i(param_addr_i),
        .param_wdata_i(param_wdata_i),
        .param_from_keypad_i(param_from_keypad_i),
        .keys_held_i(keys_held_i),
        .param_rdata_o(param_rdata_o),
        .busy_o(busy_o),
        .init_done_o(init_done_o),
        .save_done_o(save_done_o),
        .write_refused_o(write_refused_o),
        .user_image_valid_o(user_image_valid_o)
    );
    initial forever #12.5 clock_i = ~clock_i;
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    // One write strobe, raised one edge after the call so that two calls
    // never lower and raise it in one step; returns after the taking edge.
    task automatic wr(input logic [4:0] a, input logic [15:0] d,
                      input logic kp = 1'b0);
        @(posedge clock_i);
        #1;
        param_wr_i = 1'b1;
        param_addr_i = a;
        param_wdata_i = d;
        param_from_keypad_i = kp;
        @(posedge clock_i);
        #1;
        param_wr_i = 1'b0;
        param_from_keypad_i = 1'b0;
    endtask
    // Command or save trigger write, then the done pulses.
    task automatic op(input logic [4:0] a, input logic [15:0] d,
                      input logic ei, es);
        wr(a, d);
        chk(busy_o, d != 16'h0000);
        @(posedge clock_i);
        #1;
        chk(init_done_o, ei);
        chk(save_done_o, es);
    endtask
    // Model reload of a range from the image or the factory table.
    task automatic reload(input int lo, hi, input bit usr);
        for (int i = lo; i <= hi; i++) begin
            mdl[i] = usr ? img[i] : pis_pkg::FACTORY_DEFAULTS[i];
        end
        mdl[0] = 16'h0000;
    endtask
    task automatic rnd(input int lo, hi);
        for (int i = lo; i <= hi; i++) begin
            mdl[i] = 16'($urandom);
            wr(5'(i), mdl[i]);
        end
    endtask
    // Reads every entry back and compares it with the model.
    task automatic cmp_all();
        for (int i = 0; i < 32; i++) begin
            param_addr_i = 5'(i);
            @(posedge clock_i);
            #1;
            chk(param_rdata_o, mdl[i]);
        end
    endtask
    // Expected motor constant at index i for capacity c and motor type t.
    function automatic logic [15:0] mot(input int c, t, i);
        int r;
        int s;
        bit hp;
        r = pis_pkg::NUM_RATINGS - 1;
        for (int j = pis_pkg::NUM_RATINGS - 1; j >= 0; j--) begin
            if (c <= int'(pis_pkg::STD_RATINGS[j])) r = j;
        end
        hp = (t == 1);
        s = int'(pis_pkg::STD_RATINGS[r]);
        s = s * (hp ? int'(pis_pkg::CUR_K_HP) : int'(pis_pkg::CUR_K_STD));
        s = s / int'(pis_pkg::PCT_DIV);
        case (i)
            6: return 16'(s);
            7: return 16'(s * int'(pis_pkg::NOLOAD_PCT) /
                          int'(pis_pkg::PCT_DIV));
            8: return hp ? pis_pkg::R1_HP : pis_pkg::R1_STD;
            9: return hp ? pis_pkg::X_HP : pis_pkg::X_STD;
            10: return hp ? pis_pkg::RELATED_HP : pis_pkg::RELATED_STD;
            default: return pis_pkg::SEARCH_DELAYS[r];
        endcase
    endfunction
    initial begin
        void'($urandom(60717));
        repeat (6) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        reload(0, 31, 0);
        cmp_all();
        op(5'h02, 16'h0001, 0, 0);
        chk(user_image_valid_o, 1'b0);
        wr(5'h01, 16'h0001, 1'b1);
        chk(write_refused_o, 1'b1);
        keys_held_i = 1'b1;
        wr(5'h01, 16'h0001, 1'b1);
        chk(write_refused_o, 1'b0);
        keys_held_i = 1'b0;
        op(5'h00, 16'h0001, 1, 0);
        cmp_all();
        wr(5'h01, 16'h0001);
        mdl[1] = 16'h0001;
        rnd(12, 31);
        img = mdl;
        op(5'h02, 16'h0001, 0, 1);
        chk(user_image_valid_o, 1'b1);
        wr(5'h03, 16'h0001);
        mdl[3] = 16'h0001;
        rnd(16, 31);
        op(5'h02, 16'h0001, 0, 0);
        cmp_all();
        op(5'h00, 16'h000C, 1, 0);
        reload(16, 23, 0);
        cmp_all();
        op(5'h00, 16'h0001, 1, 0);
        reload(0, 31, 1);
        cmp_all();
        rnd(12, 31);
        op(5'h00, 16'h000B, 1, 0);
        reload(0, 11, 0);
        reload(16, 31, 0);
        cmp_all();
        // A random capacity, then one beyond the largest rating.
        for (int k = 0; k < 2; k++) begin
            cap = k ? 65535 : $urandom_range(1, 1500);
            wr(5'h04, k ? 16'h0001 : 16'h0004);
            mdl[4] = k ? 16'h0001 : 16'h0004;
            wr(5'h05, 16'(cap));
            mdl[5] = 16'(cap);
            for (int i = 6; i < 12; i++) mdl[i] = mot(cap, mdl[4], i);
            // A type change alone leaves the derived constants alone.
            wr(5'h04, k ? 16'h0000 : 16'h0001);
            mdl[4] = k ? 16'h0000 : 16'h0001;
            cmp_all();
            op(5'h00, 16'h0002, 1, 0);
            for (int i = 6; i < 12; i++) mdl[i] = mot(cap, mdl[4], i);
            cmp_all();
        end
        op(5'h00, 16'h0000, 0, 0);
        // A write right behind a command is dropped; strobe held high.
        @(posedge clock_i);
        #1;
        param_wr_i = 1'b1;
        param_addr_i = 5'h00;
        param_wdata_i = 16'h0001;
        @(posedge clock_i);
        #1;
        param_addr_i = 5'h04;
        param_wdata_i = 16'h0004;
        @(posedge clock_i);
        #1;
        param_wr_i = 1'b0;
        chk(write_refused_o, 1'b1);
        chk(init_done_o, 1'b1);
        reload(0, 31, 0);
        cmp_all();
        close_out();
    end
    initial begin
        #1000000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
